// ==== three_wire_pkg.sv ====
// constants and types shared by the three-wire serial port
package three_wire_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_INDEX   = 32'hfffff2e2;
  localparam logic [31:0] FMT_INDEX    = 32'hfffff2e4;
  localparam logic [33:0] CTRL_PROD    = {2'h0, CTRL_INDEX} << 2;
  localparam logic [33:0] FMT_PROD     = {2'h0, FMT_INDEX} << 2;
  localparam logic [31:0] CTRL_ADDR    = CTRL_PROD[31:0];
  localparam logic [31:0] FMT_ADDR     = FMT_PROD[31:0];
  localparam logic [31:0] DATA_ADDR    = 32'hffffcba0;
  localparam logic [31:0] STAT_ADDR    = 32'hffffcba4;
  localparam logic [31:0] MASK_ADDR    = 32'hffffcba8;

  // ----------------------------------------------------------------
  // field positions and write masks
  // ----------------------------------------------------------------
  localparam int          CTRL_EN_BIT   = 7;
  localparam int          CTRL_MODE_BIT = 2;
  localparam int          CTRL_SRC_BIT  = 0;
  localparam logic [7:0]  CTRL_WMASK    = 8'h85;
  localparam int          FMT_POL_BIT   = 6;
  localparam int          FMT_PHA_BIT   = 5;
  localparam int          FMT_DIR_BIT   = 4;
  localparam int          FMT_LEN_MSB   = 3;
  localparam logic [7:0]  FMT_WMASK     = 8'h7f;
  localparam int          STAT_DONE_BIT = 0;
  localparam int          STAT_BUSY_BIT = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  FMT_RESET     = 8'h00;
  localparam logic [15:0] DATA_RESET    = 16'h0000;

  // ----------------------------------------------------------------
  // word length, timing, bus answers
  // ----------------------------------------------------------------
  localparam logic [4:0]  LEN_FULL      = 5'h10;
  localparam logic [4:0]  LEN_BASE      = 5'h08;
  localparam logic [7:0]  BAUD_HALF_CYC = 8'h08;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic {
    XFER_IDLE  = 1'b0,
    XFER_SHIFT = 1'b1
  } xfer_state_t;

endpackage

// ==== baud_tick_gen.sv ====
// half-period tick generator for the internal serial clock
`timescale 1ns/100ps
module baud_tick_gen
  import three_wire_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic run,
  output logic      tick
);

  logic [7:0] cnt_reg;
  wire        wrap = (cnt_reg == BAUD_HALF_CYC - 8'h01);

  // restarts on each run so the first half period is full length
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_reg <= 8'h00;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= wrap ? 8'h00 : cnt_reg + 8'h01;
      tick    <= wrap;
    end
  end

endmodule

// ==== three_wire_serial.sv ====
// three-wire variable-length serial port with axi4-lite registers
//
// Functional notes
// - three lines: clock, data out, data in
// - enable bit runs shifter, counter, pins
// - mode 0: drive out, write starts
// - mode 1: out released, read starts
// - source bit: 0 external, 1 internal
// - length field: 0000=16, 1xxx=8..15
// - direction bit: 1 msb first
// - one bit per serial clock cycle
// - polarity 0 idles high, 1 low
// - equal bits sample rising, else falling
// - phase bit shifts timing half period
// - done raised on final clock edge
// - after last bit stop, set flag
// - start only enabled and idle
// - write before enable never starts
`timescale 1ns/100ps
module three_wire_serial
  import three_wire_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe_n,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe_n,
  input  wire logic        serial_in_pin_i,
  output logic             transfer_done_irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] word_len(input logic [3:0] f);
    if (f[3])
      word_len = LEN_BASE + {2'h0, f[2:0]};
    else
      word_len = LEN_FULL;
  endfunction

  function automatic logic out_bit(input logic [15:0] s, input logic msb,
                                   input logic [4:0] n);
    logic [3:0] top;
    top = 4'(n - 5'h01);
    out_bit = msb ? s[top] : s[0];
  endfunction

  function automatic logic [15:0] shift_in(input logic [15:0] s, input logic b,
                                           input logic msb, input logic [4:0] n);
    logic [15:0] r;
    logic [3:0]  top;
    top = 4'(n - 5'h01);
    if (msb) begin
      r = {s[14:0], b};
    end else begin
      r = s >> 1;
      r[top] = b;
    end
    shift_in = r & (16'hffff >> (5'h10 - n));
  endfunction

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_reg;
  logic [7:0]  fmt_reg;
  logic [15:0] shift_reg;
  logic        done_reg;
  logic        mask_reg;
  xfer_state_t state_reg;
  logic [4:0]  bitcnt_reg;
  logic [4:0]  len_reg;
  logic        half_reg;
  logic        smp_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [31:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        sck_meta_reg;
  logic        sck_sync_reg;
  logic        sck_prev_reg;
  logic        si_meta_reg;
  logic        si_sync_reg;
  logic        tick;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire en       = ctrl_reg[CTRL_EN_BIT];
  wire rx_only  = ctrl_reg[CTRL_MODE_BIT];
  wire int_src  = ctrl_reg[CTRL_SRC_BIT];
  wire pol      = fmt_reg[FMT_POL_BIT];
  wire pha      = fmt_reg[FMT_PHA_BIT];
  wire msb      = fmt_reg[FMT_DIR_BIT];
  wire busy     = (state_reg == XFER_SHIFT);

  wire wr_go    = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire wr_ctrl  = wr_go && (awaddr_reg == CTRL_ADDR) && wstrb_reg[0];
  wire wr_fmt   = wr_go && (awaddr_reg == FMT_ADDR) && wstrb_reg[0];
  wire wr_data  = wr_go && (awaddr_reg == DATA_ADDR);
  wire wr_stat  = wr_go && (awaddr_reg == STAT_ADDR) && wstrb_reg[0];
  wire wr_mask  = wr_go && (awaddr_reg == MASK_ADDR) && wstrb_reg[0];
  wire wr_hit   = wr_ctrl || wr_fmt || wr_data || wr_stat || wr_mask;
  wire wr_known = (awaddr_reg == CTRL_ADDR) || (awaddr_reg == FMT_ADDR) ||
                  (awaddr_reg == DATA_ADDR) || (awaddr_reg == STAT_ADDR) ||
                  (awaddr_reg == MASK_ADDR);

  wire ar_take  = s_axi_arvalid && s_axi_arready;
  wire rd_data  = ar_take && (s_axi_araddr == DATA_ADDR);

  // data register write merges only the enabled byte lanes
  wire [15:0] data_wr = {wstrb_reg[1] ? wdata_reg[15:8] : shift_reg[15:8],
                         wstrb_reg[0] ? wdata_reg[7:0]  : shift_reg[7:0]};

  // no pending start is remembered, so an early write cannot fire later
  wire start_ev = en && !busy && (rx_only ? rd_data : wr_data);
  wire [15:0] load_val = rx_only ? shift_reg : data_wr;
  wire [4:0]  cfg_len  = word_len(fmt_reg[FMT_LEN_MSB:0]);

  // ----------------------------------------------------------------
  // serial clock edges
  // ----------------------------------------------------------------
  wire ext_rise  = sck_sync_reg && !sck_prev_reg;
  wire ext_fall  = !sck_sync_reg && sck_prev_reg;
  wire ext_lead  = pol ? ext_rise : ext_fall;
  wire ext_trail = pol ? ext_fall : ext_rise;
  wire lead_ev   = busy && (int_src ? (tick && !half_reg) : ext_lead);
  wire trail_ev  = busy && (int_src ? (tick && half_reg) : ext_trail);
  // phase 1 samples on the leading edge, phase 0 on the trailing one
  wire in_bit    = pha ? smp_reg : si_sync_reg;
  wire [15:0] shifted  = shift_in(shift_reg, in_bit, msb, len_reg);
  wire        last_bit = (bitcnt_reg + 5'h01 == len_reg);
  wire        final_ev = trail_ev && last_bit;
  // pin follows the next half_reg so the final edge lands with done
  wire        sck_active = en && busy && int_src && (half_reg ^ tick);

  baud_tick_gen u_baud (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (busy && int_src),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_meta_reg <= 1'b0;
      sck_sync_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
      si_meta_reg  <= 1'b0;
      si_sync_reg  <= 1'b0;
    end else begin
      sck_meta_reg <= serial_clock_pin_i;
      sck_sync_reg <= sck_meta_reg;
      sck_prev_reg <= sck_sync_reg;
      si_meta_reg  <= serial_in_pin_i;
      si_sync_reg  <= si_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      fmt_reg  <= FMT_RESET;
      mask_reg <= 1'b0;
    end else begin
      if (wr_ctrl)
        ctrl_reg <= wdata_reg[7:0] & CTRL_WMASK;
      if (wr_fmt)
        fmt_reg <= wdata_reg[7:0] & FMT_WMASK;
      if (wr_mask)
        mask_reg <= wdata_reg[STAT_DONE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg  <= XFER_IDLE;
      shift_reg  <= DATA_RESET;
      bitcnt_reg <= 5'h00;
      len_reg    <= LEN_FULL;
      half_reg   <= 1'b0;
      smp_reg    <= 1'b0;
      serial_out_pin_o <= 1'b0;
    end else if (!en) begin
      state_reg  <= XFER_IDLE;
      bitcnt_reg <= 5'h00;
      half_reg   <= 1'b0;
      if (wr_data)
        shift_reg <= data_wr;
    end else begin
      unique case (state_reg)
        XFER_IDLE: begin
          if (wr_data && !rx_only)
            shift_reg <= data_wr;
          if (start_ev) begin
            state_reg  <= XFER_SHIFT;
            bitcnt_reg <= 5'h00;
            len_reg    <= cfg_len;
            half_reg   <= 1'b0;
            // phase 1 presents the first bit before any clock edge
            if (pha)
              serial_out_pin_o <= out_bit(load_val, msb, cfg_len);
          end
        end
        XFER_SHIFT: begin
          if (int_src && tick)
            half_reg <= !half_reg;
          if (lead_ev) begin
            if (pha)
              smp_reg <= si_sync_reg;
            else
              serial_out_pin_o <= out_bit(shift_reg, msb, len_reg);
          end
          if (trail_ev) begin
            shift_reg  <= shifted;
            bitcnt_reg <= bitcnt_reg + 5'h01;
            if (pha)
              serial_out_pin_o <= out_bit(shifted, msb, len_reg);
            if (last_bit) begin
              state_reg <= XFER_IDLE;
              half_reg  <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pins, status and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_clock_pin_o    <= 1'b1;
      serial_clock_pin_oe_n <= 1'b1;
      serial_out_pin_oe_n   <= 1'b1;
      done_reg              <= 1'b0;
      transfer_done_irq     <= 1'b0;
    end else begin
      // idle level is the inverse of the active level
      serial_clock_pin_o    <= sck_active ? pol : !pol;
      serial_clock_pin_oe_n <= !(en && int_src);
      serial_out_pin_oe_n   <= !(en && !rx_only);
      // a completion in the clearing cycle still sets the flag
      done_reg <= final_ev || (done_reg && !(wr_stat && wdata_reg[STAT_DONE_BIT]));
      transfer_done_irq <= (final_ev || done_reg) && mask_reg;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 32'h00000000;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_known && (wr_hit || wstrb_reg == 4'h0 || !wstrb_reg[0]))
                        ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  wire        rd_known = (s_axi_araddr == CTRL_ADDR) || (s_axi_araddr == FMT_ADDR) ||
                         (s_axi_araddr == DATA_ADDR) || (s_axi_araddr == STAT_ADDR) ||
                         (s_axi_araddr == MASK_ADDR);
  wire [31:0] rd_mux =
    (s_axi_araddr == CTRL_ADDR) ? {24'h000000, ctrl_reg} :
    (s_axi_araddr == FMT_ADDR)  ? {24'h000000, fmt_reg} :
    (s_axi_araddr == DATA_ADDR) ? {16'h0000, shift_reg} :
    (s_axi_araddr == STAT_ADDR) ? {30'h00000000, busy, done_reg} :
    (s_axi_araddr == MASK_ADDR) ? {31'h00000000, mask_reg} : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

endmodule

// ==== three_wire_serial_checker.sv ====
// assertion checker for the three-wire serial port
`timescale 1ns/100ps
module three_wire_serial_checker
  import three_wire_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        serial_clock_pin_o,
  input wire logic        serial_clock_pin_oe_n,
  input wire logic        serial_out_pin_oe_n,
  input wire logic        transfer_done_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire mapped  = s_axi_araddr == CTRL_ADDR || s_axi_araddr == FMT_ADDR
              || s_axi_araddr == DATA_ADDR || s_axi_araddr == STAT_ADDR
              || s_axi_araddr == MASK_ADDR;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  chk_read_answer: assert property (ar_take |=> s_axi_rvalid)
    else $error("read data missing");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_unmapped_err: assert property (ar_take && !mapped
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  chk_no_overlap: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken while response pending");
  chk_half_period: assert property ($changed(serial_clock_pin_o) && !serial_clock_pin_oe_n
    |=> ($stable(serial_clock_pin_o) || serial_clock_pin_oe_n)[*7])
    else $error("serial clock half period short");
  chk_stop_after: assert property ($rose(transfer_done_irq)
    |=> $stable(serial_clock_pin_o)[*4]) else $error("clock runs after done");
  chk_reset_release: assert property ($rose(aresetn)
    |-> serial_clock_pin_oe_n && serial_out_pin_oe_n) else $error("pins driven at reset");
  cover property ($rose(transfer_done_irq));
  cover property (ar_take && !mapped);
  cover property (!serial_clock_pin_oe_n && $changed(serial_clock_pin_o));
endmodule

bind three_wire_serial three_wire_serial_checker chk (.*);

// ==== serial_peer_model.sv ====
// behavioural far-side peripheral for the serial link
`timescale 1ns/100ps
module serial_peer_model (
  input  wire logic        sclk,
  input  wire logic        sdo,
  input  wire logic        arm,
  input  wire logic        samp_rise,
  input  wire logic        msb_first,
  input  wire logic [4:0]  len,
  input  wire logic [15:0] tx_word,
  output logic             sdi,
  output logic [15:0]      rx_word,
  output logic [4:0]       n_samp
);
  logic [4:0] idx  = 5'h1f;
  logic       seen = 1'b0;
  logic [4:0] bit_i;
  always @(posedge arm) begin
    idx = 5'h0;
    n_samp = 5'h0;
    rx_word = 16'h0;
    seen = 1'b0;
  end
  // sample and change on opposite edges
  always @(sclk) begin
    if (sclk === samp_rise) begin
      if (msb_first)
        rx_word = {rx_word[14:0], sdo};
      else
        rx_word[n_samp[3:0]] = sdo;
      n_samp = n_samp + 5'h1;
      seen = 1'b1;
    end else if (seen) begin
      idx = idx + 5'h1;
      seen = 1'b0;
    end
  end
  assign bit_i = msb_first ? len - 5'h1 - idx : idx;
  // past the word the line shows the inverse, not a stale bit
  assign sdi = (idx < len) ? tx_word[bit_i[3:0]]
             : ~tx_word[msb_first ? 4'h0 : len[3:0] - 4'h1];
endmodule

// ==== variable_length_three_wire_serial_test.sv ====
// self-checking bench for the three-wire serial port
`timescale 1ns/100ps
module variable_length_three_wire_serial_test;
  import three_wire_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, transfer_done_irq;
  logic        serial_clock_pin_o, serial_clock_pin_oe_n, serial_out_pin_o;
  logic        serial_out_pin_oe_n, ext_clk, arm, samp, msb;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [4:0]  plen, nsamp;
  logic [15:0] ptx, prx;
  wire         serial_in_pin_i;
  wire         serial_clock_pin_i = serial_clock_pin_oe_n ? ext_clk : serial_clock_pin_o;
  int          n_errors = 0;
  int          n_checks = 0;
  three_wire_serial uut (.*);
  serial_peer_model peer (.sclk(serial_clock_pin_i), .sdo(serial_out_pin_o), .arm(arm),
    .samp_rise(samp), .msb_first(msb), .len(plen), .tx_word(ptx), .sdi(serial_in_pin_i),
    .rx_word(prx), .n_samp(nsamp));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_idle();
    do rd(STAT_ADDR); while (v[STAT_BUSY_BIT] !== 1'b0);
  endtask
  task automatic peer_setup(input logic [7:0] f, input logic [15:0] t);
    samp <= f[6] ~^ f[5];
    msb <= f[4];
    plen <= f[3] ? {2'h0, f[2:0]} + LEN_BASE : LEN_FULL;
    ptx <= t;
    arm <= 1'b1;
    @(posedge aclk);
    arm <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic reg_defaults();
    rd(CTRL_ADDR); check("ctrl reset", v, 32'h0);
    rd(FMT_ADDR); check("fmt reset", v, 32'h0);
    rd(32'h0); check("unmapped rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    check("unmapped rdata", v, 32'h0);
    wr(32'h0, 32'h1); check("unmapped bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    wr(MASK_ADDR, 32'h1);
  endtask
  task automatic run_xfer(input logic [7:0] f, input logic [15:0] d);
    logic [15:0] m;
    wr(FMT_ADDR, {24'h0, f});
    wr(CTRL_ADDR, 32'h81);
    check("idle clock", {31'h0, serial_clock_pin_o}, {31'h0, ~f[6]});
    peer_setup(f, ~d);
    m = (plen == LEN_FULL) ? 16'hffff : (16'h1 << plen) - 16'h1;
    wr(DATA_ADDR, {16'h0, d});
    wr(DATA_ADDR, {16'h0, d ^ 16'h0ff0});
    wait_idle();
    check("sent word", {16'h0, prx}, {16'h0, d & m});
    check("clock count", {27'h0, nsamp}, {27'h0, plen});
    rd(DATA_ADDR); check("received word", v, {16'h0, ~d & m});
    check("data rresp", {30'h0, r}, {30'h0, RESP_OKAY});
    rd(STAT_ADDR); check("status", v, 32'h1);
    check("irq", {31'h0, transfer_done_irq}, 32'h1);
    wr(MASK_ADDR, 32'h0);
    @(posedge aclk);
    check("masked irq", {31'h0, transfer_done_irq}, 32'h0);
    wr(MASK_ADDR, 32'h1);
    wr(STAT_ADDR, 32'h1);
    @(posedge aclk);
    check("cleared irq", {31'h0, transfer_done_irq}, 32'h0);
    rd(STAT_ADDR);
    check("done flag", v, 32'h0);
  endtask
  task automatic recv_only();
    wr(FMT_ADDR, 32'h18);
    wr(CTRL_ADDR, 32'h85);
    peer_setup(8'h18, 16'h00c6);
    rd(DATA_ADDR);
    check("out released", {31'h0, serial_out_pin_oe_n}, 32'h1);
    wait_idle();
    rd(DATA_ADDR); check("rx only word", v, 32'hc6);
    wait_idle();
    wr(STAT_ADDR, 32'h1);
  endtask
  task automatic ext_clock();
    wr(CTRL_ADDR, 32'h80);
    peer_setup(8'h18, 16'h0000);
    wr(DATA_ADDR, 32'h5a);
    check("clock released", {31'h0, serial_clock_pin_oe_n}, 32'h1);
    repeat (16) begin
      repeat (10) @(posedge aclk);
      ext_clk <= ~ext_clk;
    end
    repeat (10) @(posedge aclk);
    rd(STAT_ADDR); check("ext done", v, 32'h1);
    check("ext word", {16'h0, prx}, 32'h5a);
    wr(STAT_ADDR, 32'h1);
  endtask
  task automatic disable_case();
    wr(CTRL_ADDR, 32'h0);
    @(posedge aclk);
    check("pins off", {30'h0, serial_clock_pin_oe_n, serial_out_pin_oe_n}, 32'h3);
    wr(DATA_ADDR, 32'h33);
    wr(CTRL_ADDR, 32'h81);
    rd(STAT_ADDR); check("late enable", v, 32'h0);
    wr(DATA_ADDR, 32'hffff);
    rd(STAT_ADDR); check("busy", v, 32'h2);
    wr(CTRL_ADDR, 32'h0);
    rd(STAT_ADDR); check("aborted", v, 32'h0);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    repeat (40000) @(posedge aclk);
    n_errors++;
    print_verdict();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h0;
    {s_axi_rready, arm, samp, msb} = 4'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    ext_clk = 1'b1;
    plen = LEN_FULL;
    ptx = 16'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    reg_defaults();
    for (int i = 0; i < 9; i++)
      run_xfer({1'b0, i[1:0], i[2], (i == 8) ? 4'h0 : 4'h8 + 4'(i)}, 16'h9c3a + 16'(i) * 16'h1357);
    recv_only();
    ext_clock();
    disable_case();
    print_verdict();
  end
endmodule
